// >>> verilog/pbg_port.sv
// port b gpio: eight pins with direction, output latch, pin readback, pull-ups
// and the two host-interface sideband outputs, behind a classic wishbone slave.
// assumes a single 40 mhz clock and pins already synchronous to it.
//
// What this block does
// - direction bit one drives, zero listens
// - direction is write-only; read gives port seven
// - output latch always readable, writable, resets zero
// - pin-levels read returns live pin levels
// - pin-levels write loads port eight direction
// - pins seven to two: direction only, wake-up always
// - sci enable makes pin one the sideband
// - pin one always feeds wake-up and sci input
// - smi enable makes pin zero the sideband
// - pin zero always feeds wake-up and smi input
// - per-pin software pull-up
// - pull-up off on peripheral output pins
// - pull-ups off in reset and hardware standby
// - pull-up on when input and latch one
`timescale 1ns/1ps
`default_nettype none
`include "pbg_cfg.svh"

module pbg_port (
   input wire logic clk,
   input wire logic srst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins
   input wire pbg_pkg::pbg_byte_type pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] pin_pullup_en,
   // system and neighbours
   input wire logic hw_standby,
   input wire pbg_pkg::pbg_byte_type port_seven_pin_levels,
   output logic [7:0] port_eight_direction,
   output logic [7:0] wakeup_event_input,
   // host interface sidebands
   input wire logic sci_sideband_enable,
   input wire logic smi_sideband_enable,
   input wire logic host_sci_sideband_out,
   input wire logic host_smi_sideband_out,
   output logic host_sci_sideband_in,
   output logic host_smi_sideband_in
);
   import pbg_pkg::*;

   pbg_state_type state;
   pbg_state_type next_state;

   // ******************************
   // helpers
   // ******************************
   function automatic logic hit(
      input logic [7:0] adr,
      input logic [7:0] ofs
   );
      hit = (adr == ofs);
   endfunction

   function automatic logic [31:0] widen(
      input pbg_byte_type b
   );
      widen = {24'h00_0000, b};
   endfunction

   // a request is taken only while ack is low, so a strobe still high in the ack cycle is not taken again
   function automatic logic taken(
      input logic cyc,
      input logic stb,
      input logic ack_now
   );
      taken = cyc & stb & ~ack_now;
   endfunction

   // only the low byte lane carries register bits
   function automatic logic lane_zero(
      input logic we,
      input logic [3:0] sel
   );
      lane_zero = we & sel[0];
   endfunction

   // read mux: the direction address answers with port seven, the pin address with live pins
   function automatic logic [31:0] read_word(
      input logic [7:0] adr,
      input pbg_byte_type seven,
      input pbg_byte_type latch,
      input pbg_byte_type pins
   );
      logic [31:0] word;
      word = `PBG_RST_WORD;
      if (hit(adr, `PBG_OFS_DIR)) begin
         word = widen(seven);
      end else if (hit(adr, `PBG_OFS_LATCH)) begin
         word = widen(latch);
      end else if (hit(adr, `PBG_OFS_PINS)) begin
         word = widen(pins);
      end
      read_word = word;
   endfunction

   // level driven onto one pin; a sideband owner wins over the latch
   function automatic logic drive_level(
      input logic periph_en,
      input logic periph_lvl,
      input logic latch_bit
   );
      if (periph_en) begin
         drive_level = periph_lvl;
      end else begin
         drive_level = latch_bit;
      end
   endfunction

   // the sideband drives even if software left the direction bit clear
   function automatic logic drive_enable(
      input logic periph_en,
      input logic dir_bit
   );
      if (periph_en) begin
         drive_enable = 1'h1;
      end else begin
         drive_enable = dir_bit;
      end
   endfunction

   // pull-up only on a software input with its latch bit high
   function automatic logic pull_on(
      input logic standby,
      input logic periph_en,
      input logic dir_bit,
      input logic latch_bit
   );
      logic allowed;
      allowed = ~standby & ~periph_en;
      pull_on = allowed & ~dir_bit & latch_bit;
   endfunction

   // ******************************
   // bus handshake
   // ******************************
   logic req;
   logic wr;
   logic rd;
   logic sel_dir;
   logic sel_latch;
   logic sel_pins;

   assign req = taken(wb_cyc_i, wb_stb_i, state.ack);
   assign wr = req & lane_zero(wb_we_i, wb_sel_i);
   assign rd = req & ~wb_we_i;

   // address decode for the write strobes
   assign sel_dir = hit(wb_adr_i, `PBG_OFS_DIR);
   assign sel_latch = hit(wb_adr_i, `PBG_OFS_LATCH);
   assign sel_pins = hit(wb_adr_i, `PBG_OFS_PINS);

   // ******************************
   // next state
   // ******************************
   logic [7:0] periph_out;
   logic [7:0] periph_oe;

   always_comb begin
      next_state = state;

      // bus: one wait-free answer, ack drops the cycle after
      next_state.ack = req;
      next_state.dat = `PBG_RST_WORD;
      if (rd) begin
         next_state.dat = read_word(wb_adr_i, port_seven_pin_levels,
            state.output_latch, pin_in);
      end

      // write to the direction address
      if (wr && sel_dir) begin
         next_state.direction = wb_dat_i[7:0];
      end

      // the output latch takes writes whatever the direction bits hold
      if (wr && sel_latch) begin
         next_state.output_latch = wb_dat_i[7:0];
      end

      // the pin-levels register is read-only; its address loads port eight direction
      if (wr && sel_pins) begin
         next_state.eight_direction = wb_dat_i[7:0];
      end

      // peripheral takeover of pins one and zero
      periph_out = 8'h00;
      periph_oe = 8'h00;
      periph_out[`PBG_PIN_SCI] = host_sci_sideband_out;
      periph_oe[`PBG_PIN_SCI] = sci_sideband_enable;
      periph_out[`PBG_PIN_SMI] = host_smi_sideband_out;
      periph_oe[`PBG_PIN_SMI] = smi_sideband_enable;

      // pins seven to two never have a peripheral owner, so periph_oe stays low there
      // pin seven
      next_state.pin_out[7] = drive_level(periph_oe[7], periph_out[7],
         state.output_latch[7]);
      next_state.pin_oe[7] = drive_enable(periph_oe[7],
         state.direction[7]);
      next_state.pullup_en[7] = pull_on(hw_standby, periph_oe[7],
         state.direction[7],
         state.output_latch[7]);

      // pin six
      next_state.pin_out[6] = drive_level(periph_oe[6], periph_out[6],
         state.output_latch[6]);
      next_state.pin_oe[6] = drive_enable(periph_oe[6],
         state.direction[6]);
      next_state.pullup_en[6] = pull_on(hw_standby, periph_oe[6],
         state.direction[6],
         state.output_latch[6]);

      // pin five
      next_state.pin_out[5] = drive_level(periph_oe[5], periph_out[5],
         state.output_latch[5]);
      next_state.pin_oe[5] = drive_enable(periph_oe[5],
         state.direction[5]);
      next_state.pullup_en[5] = pull_on(hw_standby, periph_oe[5],
         state.direction[5],
         state.output_latch[5]);

      // pin four
      next_state.pin_out[4] = drive_level(periph_oe[4], periph_out[4],
         state.output_latch[4]);
      next_state.pin_oe[4] = drive_enable(periph_oe[4],
         state.direction[4]);
      next_state.pullup_en[4] = pull_on(hw_standby, periph_oe[4],
         state.direction[4],
         state.output_latch[4]);

      // pin three
      next_state.pin_out[3] = drive_level(periph_oe[3], periph_out[3],
         state.output_latch[3]);
      next_state.pin_oe[3] = drive_enable(periph_oe[3],
         state.direction[3]);
      next_state.pullup_en[3] = pull_on(hw_standby, periph_oe[3],
         state.direction[3],
         state.output_latch[3]);

      // pin two
      next_state.pin_out[2] = drive_level(periph_oe[2], periph_out[2],
         state.output_latch[2]);
      next_state.pin_oe[2] = drive_enable(periph_oe[2],
         state.direction[2]);
      next_state.pullup_en[2] = pull_on(hw_standby, periph_oe[2],
         state.direction[2],
         state.output_latch[2]);

      // pin one: sci sideband owner when enabled
      next_state.pin_out[1] = drive_level(periph_oe[1], periph_out[1],
         state.output_latch[1]);
      next_state.pin_oe[1] = drive_enable(periph_oe[1],
         state.direction[1]);
      next_state.pullup_en[1] = pull_on(hw_standby, periph_oe[1],
         state.direction[1],
         state.output_latch[1]);

      // pin zero: smi sideband owner when enabled
      next_state.pin_out[0] = drive_level(periph_oe[0], periph_out[0],
         state.output_latch[0]);
      next_state.pin_oe[0] = drive_enable(periph_oe[0],
         state.direction[0]);
      next_state.pullup_en[0] = pull_on(hw_standby, periph_oe[0],
         state.direction[0],
         state.output_latch[0]);

      // inputs stay live in every mux setting
      next_state.wakeup = pin_in;
      next_state.sci_in = pin_in[`PBG_PIN_SCI];
      next_state.smi_in = pin_in[`PBG_PIN_SMI];
   end

   // ******************************
   // state register
   // ******************************
   always_ff @(posedge clk) begin
      if (srst) begin
         state.direction <= `PBG_RST_DIR;
         state.output_latch <= `PBG_RST_LATCH;
         state.eight_direction <= `PBG_RST_P8DIR;
         state.pin_out <= `PBG_RST_PINS;
         state.pin_oe <= `PBG_RST_PINS;
         state.pullup_en <= `PBG_RST_PINS;
         state.wakeup <= `PBG_RST_PINS;
         state.sci_in <= `PBG_RST_BIT;
         state.smi_in <= `PBG_RST_BIT;
         state.ack <= `PBG_RST_BIT;
         state.dat <= `PBG_RST_WORD;
      end else begin
         state <= next_state;
      end
   end

   // ******************************
   // outputs
   // ******************************
   // bus side
   assign wb_dat_o = state.dat;
   assign wb_ack_o = state.ack;

   // pin drivers and pull-ups, one cycle behind the registers they follow
   assign pin_out = state.pin_out;
   assign pin_oe = state.pin_oe;
   assign pin_pullup_en = state.pullup_en;

   // neighbours
   assign port_eight_direction = state.eight_direction;
   assign wakeup_event_input = state.wakeup;

   // sideband inputs back to the host interface
   assign host_sci_sideband_in = state.sci_in;
   assign host_smi_sideband_in = state.smi_in;

endmodule

`default_nettype wire

// >>> verilog/pbg_cfg.svh
// constants for the port b gpio block: register offsets, reset values, pin positions.
// assumes a 32-bit classic wishbone bus with byte addresses on an 8-bit address port.
`ifndef PBG_CFG_SVH
`define PBG_CFG_SVH

// ******************************
// register offsets (byte address)
// ******************************
`define PBG_OFS_DIR 8'h00
`define PBG_OFS_LATCH 8'h04
`define PBG_OFS_PINS 8'h08

// ******************************
// reset values
// ******************************
`define PBG_RST_DIR 8'h00
`define PBG_RST_LATCH 8'h00
`define PBG_RST_P8DIR 8'h00
`define PBG_RST_WORD 32'h0000_0000
`define PBG_RST_PINS 8'h00
`define PBG_RST_BIT 1'h0

// ******************************
// pins shared with the host interface sidebands
// ******************************
`define PBG_PIN_SCI 1
`define PBG_PIN_SMI 0

`endif

// >>> verilog/pbg_pkg.sv
// types for the port b gpio block.
// assumes pbg_cfg.svh is on the include path.
`default_nettype none

package pbg_pkg;

   typedef logic [7:0] pbg_byte_type;

   // every flip-flop of the block lives in this one record
   typedef struct packed {
      pbg_byte_type direction;
      pbg_byte_type output_latch;
      pbg_byte_type eight_direction;
      pbg_byte_type pin_out;
      pbg_byte_type pin_oe;
      pbg_byte_type pullup_en;
      pbg_byte_type wakeup;
      logic sci_in;
      logic smi_in;
      logic ack;
      logic [31:0] dat;
   } pbg_state_type;

endpackage

`default_nettype wire

// >>> tb/pbg_board.sv
// board model for the port b pins
// a pin nobody drives and without pull-up floats, shown as a level toggling each cycle
`timescale 1ns/1ps
`default_nettype none
module pbg_board (
   input wire logic clk,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pin_pullup_en,
   input wire logic [7:0] ext,
   input wire logic [7:0] ext_en,
   output logic [7:0] pin_in
);
   logic tog = 1'h0;
   always @(posedge clk) tog <= ~tog;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext[i] : pin_pullup_en[i] | tog;
      end
   end
endmodule
`default_nettype wire

// >>> tb/pbg_port_checker.sv
// assertions on the pbg_port ports
// bound to every pbg_port instance
`timescale 1ns/1ps
`default_nettype none
module pbg_checker (
   input wire logic clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire pbg_pkg::pbg_byte_type pin_in,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pin_pullup_en,
   input wire logic hw_standby,
   input wire pbg_pkg::pbg_byte_type port_seven_pin_levels,
   input wire logic [7:0] wakeup_event_input,
   input wire logic sci_sideband_enable,
   input wire logic smi_sideband_enable,
   input wire logic host_sci_sideband_out,
   input wire logic host_smi_sideband_out,
   input wire logic host_sci_sideband_in
);
   import pbg_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle");
   property p_pins; wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h08 |=> wb_dat_o == {24'h0, $past(pin_in)}; endproperty
   a_pins: assert property (p_pins) else $error("pin read wrong");
   property p_p7; wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h00 |=> wb_dat_o == {24'h0, $past(port_seven_pin_levels)}; endproperty
   a_p7: assert property (p_p7) else $error("port seven read wrong");
   property p_sci; sci_sideband_enable |=> pin_oe[1] && pin_out[1] == $past(host_sci_sideband_out) && !pin_pullup_en[1]; endproperty
   a_sci: assert property (p_sci) else $error("sci pin wrong");
   property p_smi; smi_sideband_enable |=> pin_oe[0] && pin_out[0] == $past(host_smi_sideband_out) && !pin_pullup_en[0]; endproperty
   a_smi: assert property (p_smi) else $error("smi pin wrong");
   property p_pu; (pin_pullup_en & pin_oe) == 8'h00; endproperty
   a_pu: assert property (p_pu) else $error("pull-up on output");
   property p_stby; hw_standby |=> pin_pullup_en == 8'h00; endproperty
   a_stby: assert property (p_stby) else $error("pull-up in standby");
   property p_wue; !$past(srst) |-> wakeup_event_input == $past(pin_in) && host_sci_sideband_in == $past(pin_in[1]); endproperty
   a_wue: assert property (p_wue) else $error("wake-up copy wrong");
endmodule
bind pbg_port pbg_checker checker_i (.*);
`default_nettype wire

// >>> tb/test_port_b_gpio_with_wakeup_mux.sv
// testbench for pbg_port: wishbone register access, then pin mux and pull-ups
// pbg_board stands for the pins
`timescale 1ns/1ps
`default_nettype none
module test_port_b_gpio_with_wakeup_mux;
   import pbg_pkg::*;
   logic clk = 1'h0, srst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, hw_standby = 1'h0;
   logic sci_sideband_enable = 1'h0, smi_sideband_enable = 1'h0, host_sci_sideband_out = 1'h1, host_smi_sideband_out = 1'h0;
   logic [7:0] wb_adr_i = 8'h00, ext = 8'h00, ext_en = 8'h00, pin_out, pin_oe, pin_pullup_en;
   logic [7:0] port_eight_direction, wakeup_event_input;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, host_sci_sideband_in, host_smi_sideband_in;
   pbg_byte_type pin_in, port_seven_pin_levels = 8'h3c;
   int mismatches = 0, tests_run = 0;
   pbg_port dut (.*);
   pbg_board board (.*);
   always #12.5 clk = ~clk;
   task give_verdict;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 20);
      if (wb_ack_o !== 1'h1) begin
         mismatches++;
         give_verdict();
      end else begin
         rd = wb_dat_o;
         wb_cyc_i <= 1'h0;
         wb_stb_i <= 1'h0;
         @(posedge clk);
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'h0;
      @(posedge clk);
      chk("oe", 8'h00, pin_oe);
      chk("pullup", 8'h00, pin_pullup_en);
      bus(1'h1, 8'h00, 32'hf0);
      bus(1'h1, 8'h04, 32'ha5);
      bus(1'h0, 8'h04, 32'h0);
      chk("latch", 32'ha5, rd);
      bus(1'h0, 8'h00, 32'h0);
      chk("port7", 32'h3c, rd);
      chk("oe", 8'hf0, pin_oe);
      chk("out", 8'ha5, pin_out);
      chk("pullup", 8'h05, pin_pullup_en);
      ext_en <= 8'h0f;
      ext <= 8'h09;
      bus(1'h0, 8'h08, 32'h0);
      chk("pins", 32'ha9, rd);
      chk("wakeup", 8'ha9, wakeup_event_input);
      bus(1'h1, 8'h08, 32'h5a);
      chk("port8", 8'h5a, port_eight_direction);
      bus(1'h1, 8'h0c, 32'hff);
      bus(1'h0, 8'h0c, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("register test done");
      sci_sideband_enable <= 1'h1;
      smi_sideband_enable <= 1'h1;
      ext_en <= 8'h0c;
      repeat (3) @(posedge clk);
      chk("oe", 8'hf3, pin_oe);
      chk("out", 8'ha6, pin_out);
      chk("pullup", 8'h04, pin_pullup_en);
      chk("sideband in", 2'h2, {host_sci_sideband_in, host_smi_sideband_in});
      hw_standby <= 1'h1;
      repeat (2) @(posedge clk);
      chk("pullup", 8'h00, pin_pullup_en);
      $display("pin test done");
      give_verdict();
   end
endmodule
`default_nettype wire
